// ---- inc/venc_map.svh ----
// register map, field positions, reset values and timing counts of the encoder
`ifndef VENC_MAP_SVH
`define VENC_MAP_SVH
`define VENC_ADDR_MODE0   8'h00
`define VENC_ADDR_MODE2   8'h01
`define VENC_ADDR_STAT    8'h02
`define VENC_ADDR_LUMA    8'h03
`define VENC_ADDR_RTC     8'h04
`define VENC_M0_PAL       0
`define VENC_M0_PIX16     1
`define VENC_M0_TMODE     2
`define VENC_M0_MASTER    4
`define VENC_M0_OUTSEL    5
`define VENC_M2_PFS_LO    1
`define VENC_M2_PFS_HI    2
`define VENC_MODE0_RST    8'h00
`define VENC_MODE2_RST    8'h00
`define VENC_I2C_BASE     6'h15
`define VENC_LINE_NTSC    11'h6b4
`define VENC_LINE_PAL     11'h6c0
`define VENC_LINES_NTSC   10'h20d
`define VENC_LINES_PAL    10'h271
`define VENC_HS_WIDTH     11'h07e
`define VENC_VS_LINES     10'h003
`endif

// ---- inc/venc_pkg.sv ----
// types shared by the encoder pin-interface modules
package venc_pkg;
	typedef logic [7:0] venc_byte_t;
	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_ACK,
		I2C_SUB,
		I2C_WR,
		I2C_RD,
		I2C_RACK
	} venc_i2c_st_e;
endpackage

// ---- hdl/venc_i2c_slave.sv ----
// two-wire serial slave turning bus bytes into register strobes
`timescale 1ns/1ps
`include "venc_map.svh"
module venc_i2c_slave (
	input  wire logic                mclk_i,
	input  wire logic                rst_b_i,
	input  wire logic                addr_lsb_i,
	input  wire logic                scl_i,
	input  wire logic                sda_i,
	output logic                     sda_oe_b_o,
	output venc_pkg::venc_byte_t     reg_addr_o,
	output venc_pkg::venc_byte_t     reg_wdata_o,
	output logic                     reg_we_o,
	output logic                     reg_re_o,
	input  wire venc_pkg::venc_byte_t reg_rdata_i
);
	venc_pkg::venc_i2c_st_e st_r;
	logic       scl_q;
	logic       sda_q;
	logic [7:0] shift_r;
	logic [3:0] cnt_r;
	logic       rnw_r;
	logic       have_ptr_r;
	logic       drive_r;
	logic       load_r;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;

	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign start_c  = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_c   = scl_i & scl_q & ~sda_q & sda_i;
	assign sda_oe_b_o = ~drive_r;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r        <= venc_pkg::I2C_IDLE;
			shift_r     <= 8'h00;
			cnt_r       <= 4'h0;
			rnw_r       <= 1'b0;
			have_ptr_r  <= 1'b0;
			drive_r     <= 1'b0;
			load_r      <= 1'b0;
			reg_addr_o  <= 8'h00;
			reg_wdata_o <= 8'h00;
			reg_we_o    <= 1'b0;
			reg_re_o    <= 1'b0;
		end else begin
			reg_we_o <= 1'b0;
			reg_re_o <= 1'b0;
			load_r   <= reg_re_o;
			if (load_r) begin
				shift_r    <= reg_rdata_i;
				drive_r    <= ~reg_rdata_i[7];
				reg_addr_o <= reg_addr_o + 8'h01;
			end
			if (start_c) begin
				st_r       <= venc_pkg::I2C_ADDR;
				cnt_r      <= 4'h0;
				have_ptr_r <= 1'b0;
				drive_r    <= 1'b0;
			end else if (stop_c) begin
				st_r    <= venc_pkg::I2C_IDLE;
				drive_r <= 1'b0;
			end else begin
				case (st_r)
				venc_pkg::I2C_ADDR, venc_pkg::I2C_SUB, venc_pkg::I2C_WR: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_i};
						cnt_r   <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						cnt_r   <= 4'h0;
						drive_r <= 1'b1;
						st_r    <= venc_pkg::I2C_ACK;
						if (st_r == venc_pkg::I2C_ADDR) begin
							// [R9] pin sets address lsb
							if (shift_r[7:1] != {`VENC_I2C_BASE, addr_lsb_i}) begin
								drive_r <= 1'b0;
								st_r    <= venc_pkg::I2C_IDLE;
							end
							rnw_r <= shift_r[0];
						end else if (st_r == venc_pkg::I2C_SUB) begin
							reg_addr_o <= shift_r;
							have_ptr_r <= 1'b1;
						end else begin
							reg_wdata_o <= shift_r;
							reg_we_o    <= 1'b1;
						end
					end
				end
				venc_pkg::I2C_ACK: begin
					if (scl_fall) begin
						drive_r <= 1'b0;
						if (rnw_r) begin
							reg_re_o <= 1'b1;
							st_r     <= venc_pkg::I2C_RD;
						end else if (have_ptr_r) begin
							st_r <= venc_pkg::I2C_WR;
						end else begin
							st_r <= venc_pkg::I2C_SUB;
						end
					end
				end
				// [R10] data line returns bytes
				venc_pkg::I2C_RD: begin
					if (scl_fall) begin
						shift_r <= {shift_r[6:0], 1'b0};
						cnt_r   <= cnt_r + 4'h1;
						drive_r <= ~shift_r[6];
						if (cnt_r == 4'h7) begin
							cnt_r   <= 4'h0;
							drive_r <= 1'b0;
							st_r    <= venc_pkg::I2C_RACK;
						end
					end
				end
				venc_pkg::I2C_RACK: begin
					if (scl_rise)
						st_r <= sda_i ? venc_pkg::I2C_IDLE : venc_pkg::I2C_ACK;
				end
				default: st_r <= venc_pkg::I2C_IDLE;
				endcase
			end
		end
	end
endmodule // venc_i2c_slave

// ---- hdl/venc_timing_gen.sv ----
// line and field counter that makes or follows the sync pins
`timescale 1ns/1ps
`include "venc_map.svh"
module venc_timing_gen (
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	input  wire logic       pal_i,
	input  wire logic       master_i,
	input  wire logic [1:0] tmode_i,
	input  wire logic       ext_hs_fall_i,
	input  wire logic       ext_fs_fall_i,
	input  wire logic       ext_field_i,
	output logic            line_start_o,
	output logic            hsync_b_o,
	output logic            vsync_b_o,
	output logic            field_o
);
	logic [10:0] pix_r;
	logic [9:0]  line_r;
	logic [10:0] pix_last;
	logic [9:0]  line_last;
	logic        wrap;

	assign pix_last  = pal_i ? `VENC_LINE_PAL - 11'h001 : `VENC_LINE_NTSC - 11'h001;
	assign line_last = pal_i ? `VENC_LINES_PAL - 10'h001 : `VENC_LINES_NTSC - 10'h001;
	// slave timing restarts on the source's line sync
	assign wrap = (!master_i && ext_hs_fall_i) || (pix_r == pix_last);

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pix_r        <= 11'h000;
			line_r       <= 10'h000;
			line_start_o <= 1'b0;
		end else begin
			line_start_o <= wrap;
			pix_r        <= wrap ? 11'h000 : pix_r + 11'h001;
			if (!master_i && tmode_i == 2'h2 && ext_fs_fall_i)
				line_r <= 10'h000;
			else if (wrap)
				line_r <= (line_r == line_last) ? 10'h000 : line_r + 10'h001;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hsync_b_o <= 1'b1;
			vsync_b_o <= 1'b1;
			field_o   <= 1'b0;
		end else begin
			hsync_b_o <= ~(pix_r < `VENC_HS_WIDTH);
			vsync_b_o <= ~(line_r < `VENC_VS_LINES);
			if (!master_i && tmode_i == 2'h1)
				field_o <= ext_field_i;
			else if (wrap && line_r == line_last)
				field_o <= ~field_o;
		end
	end
endmodule // venc_timing_gen

// ---- hdl/venc_pixel_if.sv ----
// encoder pin interface: pixel capture, sync pins, subcarrier pin, mode registers
//
// Notes on behaviour
// [R1] pixel bus 8-bit muxed or 16-bit
// [R2] source supplies stable reference clock
// [R3] line sync driven in master, input in slave; the code drives it only in master timing modes 1 and 2
// [R4] frame pin field or vsync, direction by timing
// [R5] gate low means pixel bus ignored
// [R6] two selector bits choose multipurpose pin function
// [R7] falling edge resets subcarrier to field zero
// [R8] pin alternatively takes real-time phase data
// [R9] address pin sets serial address lsb
// [R10] two-wire slave with bidirectional data line
// [R11] reset restores timing generator and default modes
// [R12] source sends 4:2:2 at pixel data rate
// [R13] upper eight lines ignored in 8-bit mode
`timescale 1ns/1ps
`include "venc_map.svh"
module venc_pixel_if (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [7:0]       reg_rdata_o,
	input  wire logic [15:0] pixel_bus_i,
	input  wire logic        blank_b_i,
	input  wire logic        hsync_b_i,
	output logic             hsync_b_o,
	output logic             hsync_oe_b_o,
	input  wire logic        frame_sync_i,
	output logic             frame_sync_o,
	output logic             frame_sync_oe_b_o,
	input  wire logic        subcarrier_multipurpose_input_i,
	input  wire logic        address_select_pin_i,
	input  wire logic        serial_bus_clock_pin_i,
	input  wire logic        serial_bus_data_pin_i,
	output logic             serial_bus_data_pin_o,
	output logic             serial_bus_data_pin_oe_b_o,
	output logic [7:0]       luma_o,
	output logic [7:0]       chroma_cb_o,
	output logic [7:0]       chroma_cr_o,
	output logic             pixel_valid_o,
	output logic             pal_mode_o,
	output logic [1:0]       output_select_o,
	output logic [2:0]       sc_field_o,
	output logic [7:0]       rtc_phase_o
);
	logic [7:0]  mode0_r;
	logic [7:0]  mode2_r;
	logic [7:0]  i2c_addr;
	logic [7:0]  i2c_wdata;
	logic        i2c_we;
	logic        i2c_re;
	logic [7:0]  acc_addr;
	logic [7:0]  acc_wdata;
	logic        acc_we;
	logic [7:0]  rdata_nxt;
	logic [7:0]  rdata_r;
	logic        pal;
	logic        pix16;
	logic [1:0]  tmode;
	logic        master;
	logic        drive_sync;
	logic        pfs_hi;
	logic        pfs_lo;
	logic        scr_sel;
	logic        rtc_sel;
	logic        hs_q;
	logic        fs_q;
	logic        mp_q;
	logic        hs_fall;
	logic        fs_fall;
	logic        mp_fall;
	logic        line_start;
	logic        gen_hs_b;
	logic        gen_vs_b;
	logic        gen_field;
	logic        field_q;
	logic [1:0]  phase_r;
	logic [2:0]  sc_field_r;
	logic [7:0]  rtc_shift_r;
	logic [2:0]  rtc_cnt_r;
	logic [7:0]  rtc_phase_r;
	logic        sc_reset_seen_r;

	venc_i2c_slave u_i2c (
		.mclk_i      (mclk_i),
		.rst_b_i     (rst_b_i),
		.addr_lsb_i  (address_select_pin_i),
		.scl_i       (serial_bus_clock_pin_i),
		.sda_i       (serial_bus_data_pin_i),
		.sda_oe_b_o  (serial_bus_data_pin_oe_b_o),
		.reg_addr_o  (i2c_addr),
		.reg_wdata_o (i2c_wdata),
		.reg_we_o    (i2c_we),
		.reg_re_o    (i2c_re),
		.reg_rdata_i (rdata_r)
	);

	// the data line is open drain: it only ever pulls low
	assign serial_bus_data_pin_o = 1'b0;

	// serial bus and plain port share the mode registers, serial bus first
	assign acc_we    = i2c_we | reg_wr_i;
	assign acc_addr  = i2c_we ? i2c_addr : (i2c_re ? i2c_addr : reg_addr_i);
	assign acc_wdata = i2c_we ? i2c_wdata : reg_wdata_i;

	// [R11] default mode values
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode0_r <= `VENC_MODE0_RST;
		end else if (acc_we && acc_addr == `VENC_ADDR_MODE0) begin
			mode0_r <= acc_wdata;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode2_r <= `VENC_MODE2_RST;
		end else if (acc_we && acc_addr == `VENC_ADDR_MODE2) begin
			mode2_r <= acc_wdata;
		end
	end

	assign pal    = mode0_r[`VENC_M0_PAL];
	assign pix16  = mode0_r[`VENC_M0_PIX16];
	assign tmode  = mode0_r[`VENC_M0_TMODE +: 2];
	assign master = mode0_r[`VENC_M0_MASTER];
	assign pfs_hi = mode2_r[`VENC_M2_PFS_HI];
	assign pfs_lo = mode2_r[`VENC_M2_PFS_LO];

	// [R6] selector bits pick pin role
	assign scr_sel = ~pfs_hi & pfs_lo;
	assign rtc_sel = pfs_hi & ~pfs_lo;

	always_comb begin
		rdata_nxt = 8'h00;
		case (acc_addr)
		`VENC_ADDR_MODE0: rdata_nxt = mode0_r;
		`VENC_ADDR_MODE2: rdata_nxt = mode2_r;
		`VENC_ADDR_STAT:  rdata_nxt = {sc_reset_seen_r, field_q, phase_r, 1'b0, sc_field_r};
		`VENC_ADDR_LUMA:  rdata_nxt = luma_o;
		`VENC_ADDR_RTC:   rdata_nxt = rtc_phase_r;
		default:          rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_r <= 8'h00;
		end else if (reg_rd_i || i2c_re) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hs_q <= 1'b1;
			fs_q <= 1'b1;
			mp_q <= 1'b1;
		end else begin
			hs_q <= hsync_b_i;
			fs_q <= frame_sync_i;
			mp_q <= subcarrier_multipurpose_input_i;
		end
	end

	assign hs_fall = hs_q & ~hsync_b_i;
	assign fs_fall = fs_q & ~frame_sync_i;
	assign mp_fall = mp_q & ~subcarrier_multipurpose_input_i;

	// [R11] timing generator held in reset
	venc_timing_gen u_timing (
		.mclk_i        (mclk_i),
		.rst_b_i       (rst_b_i),
		.pal_i         (pal),
		.master_i      (master),
		.tmode_i       (tmode),
		.ext_hs_fall_i (hs_fall),
		.ext_fs_fall_i (fs_fall),
		.ext_field_i   (frame_sync_i),
		.line_start_o  (line_start),
		.hsync_b_o     (gen_hs_b),
		.vsync_b_o     (gen_vs_b),
		.field_o       (gen_field)
	);

	// [R3] [R4] pins driven only in master timing
	assign drive_sync = master && (tmode == 2'h1 || tmode == 2'h2);

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hsync_b_o         <= 1'b1;
			hsync_oe_b_o      <= 1'b1;
			frame_sync_o      <= 1'b0;
			frame_sync_oe_b_o <= 1'b1;
		end else begin
			hsync_b_o         <= gen_hs_b;
			hsync_oe_b_o      <= ~drive_sync;
			// [R4] field in mode 1, vsync in mode 2
			frame_sync_o      <= (tmode == 2'h1) ? gen_field : gen_vs_b;
			frame_sync_oe_b_o <= ~drive_sync;
		end
	end

	// [R5] gate low holds the capture
	// [R1] 8-bit stream is Cb, Y, Cr, Y
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_r       <= 2'h0;
			luma_o        <= 8'h00;
			chroma_cb_o   <= 8'h00;
			chroma_cr_o   <= 8'h00;
			pixel_valid_o <= 1'b0;
		end else if (!blank_b_i || line_start) begin
			phase_r       <= 2'h0;
			pixel_valid_o <= 1'b0;
		end else if (pix16) begin
			// [R1] 16-bit: luma low, chroma high
			phase_r       <= {1'b0, ~phase_r[0]};
			luma_o        <= pixel_bus_i[7:0];
			if (phase_r[0])
				chroma_cr_o <= pixel_bus_i[15:8];
			else
				chroma_cb_o <= pixel_bus_i[15:8];
			pixel_valid_o <= 1'b1;
		end else begin
			// [R13] only low eight lines used
			phase_r       <= phase_r + 2'h1;
			pixel_valid_o <= phase_r[0];
			case (phase_r)
			2'h0:    chroma_cb_o <= pixel_bus_i[7:0];
			2'h2:    chroma_cr_o <= pixel_bus_i[7:0];
			default: luma_o      <= pixel_bus_i[7:0];
			endcase
		end
	end

	// [R7] falling edge returns to field 0
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			field_q         <= 1'b0;
			sc_field_r      <= 3'h0;
			sc_reset_seen_r <= 1'b0;
		end else begin
			field_q <= gen_field;
			if (scr_sel && mp_fall) begin
				sc_field_r      <= 3'h0;
				sc_reset_seen_r <= 1'b1;
			end else if (field_q != gen_field) begin
				if (pal)
					sc_field_r <= sc_field_r + 3'h1;
				else
					sc_field_r <= {1'b0, sc_field_r[1:0] + 2'h1};
			end
			if (reg_rd_i && reg_addr_i == `VENC_ADDR_STAT && !(scr_sel && mp_fall))
				sc_reset_seen_r <= 1'b0;
		end
	end

	// [R8] serial phase word on pin
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rtc_shift_r <= 8'h00;
			rtc_cnt_r   <= 3'h0;
			rtc_phase_r <= 8'h00;
		end else if (!rtc_sel || line_start) begin
			rtc_cnt_r <= 3'h0;
		end else begin
			rtc_shift_r <= {rtc_shift_r[6:0], subcarrier_multipurpose_input_i};
			rtc_cnt_r   <= rtc_cnt_r + 3'h1;
			if (rtc_cnt_r == 3'h7)
				rtc_phase_r <= {rtc_shift_r[6:0], subcarrier_multipurpose_input_i};
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pal_mode_o      <= 1'b0;
			output_select_o <= 2'h0;
			sc_field_o      <= 3'h0;
			rtc_phase_o     <= 8'h00;
		end else begin
			pal_mode_o      <= pal;
			output_select_o <= mode0_r[`VENC_M0_OUTSEL +: 2];
			sc_field_o      <= sc_field_r;
			rtc_phase_o     <= rtc_phase_r;
		end
	end
endmodule // venc_pixel_if

// ---- bench/venc_pixel_if_props.sv ----
// concurrent checks on the encoder pin interface
`timescale 1ns/1ps
module venc_pixel_if_props (
	input wire logic       mclk_i,
	input wire logic       rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       blank_b_i,
	input wire logic       hsync_oe_b_o,
	input wire logic       frame_sync_oe_b_o,
	input wire logic       subcarrier_multipurpose_input_i,
	input wire logic       serial_bus_clock_pin_i,
	input wire logic       serial_bus_data_pin_o,
	input wire logic       serial_bus_data_pin_oe_b_o,
	input wire logic [7:0] luma_o,
	input wire logic       pixel_valid_o,
	input wire logic       pal_mode_o,
	input wire logic [1:0] output_select_o,
	input wire logic [2:0] sc_field_o,
	input wire logic [7:0] rtc_phase_o
);
	logic [7:0] mode0_r;
	logic [7:0] mode2_r;
	logic [2:0] age_r;
	logic       drive;
	assign drive = mode0_r[4] && (mode0_r[3:2] == 2'h1 || mode0_r[3:2] == 2'h2);
	// shadow of the port-written modes; age counts cycles since a mode0 write
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode0_r <= 8'h00;
			mode2_r <= 8'h00;
			age_r <= 3'h7;
		end else if (reg_wr_i && reg_addr_i == 8'h00) begin
			mode0_r <= reg_wdata_i;
			age_r <= 3'h0;
		end else begin
			if (reg_wr_i && reg_addr_i == 8'h01) begin
				mode2_r <= reg_wdata_i;
			end
			if (age_r != 3'h7) begin
				age_r <= age_r + 3'h1;
			end
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	property p_hs_dir; age_r == 3'h7 |-> hsync_oe_b_o == !drive; endproperty
	a_hs_dir: assert property (p_hs_dir) else $error("line sync direction");
	property p_fs_dir; age_r == 3'h7 |-> frame_sync_oe_b_o == !drive; endproperty
	a_fs_dir: assert property (p_fs_dir) else $error("frame pin direction");
	property p_gate; !blank_b_i |=> !pixel_valid_o && $stable(luma_o); endproperty
	a_gate: assert property (p_gate) else $error("capture while gated");
	property p_valid; pixel_valid_o |-> $past(blank_b_i); endproperty
	a_valid: assert property (p_valid) else $error("valid without gate");
	property p_luma; $changed(luma_o) |-> pixel_valid_o; endproperty
	a_luma: assert property (p_luma) else $error("luma moved silently");
	property p_scr;
		mode2_r[2:1] == 2'h1 && $fell(subcarrier_multipurpose_input_i) |-> ##[1:3] sc_field_o == 3'h0;
	endproperty
	a_scr: assert property (p_scr) else $error("subcarrier not reset");
	property p_rtc; $changed(rtc_phase_o) |-> mode2_r[2:1] == 2'h2; endproperty
	a_rtc: assert property (p_rtc) else $error("phase word unselected");
	property p_sda; $changed(serial_bus_data_pin_oe_b_o) |-> !serial_bus_clock_pin_i; endproperty
	a_sda: assert property (p_sda) else $error("data moved, clock high");
	property p_od; !serial_bus_data_pin_oe_b_o |-> !serial_bus_data_pin_o; endproperty
	a_od: assert property (p_od) else $error("data line driven high");
	property p_rst;
		$rose(rst_b_i) |-> hsync_oe_b_o && frame_sync_oe_b_o && serial_bus_data_pin_oe_b_o
			&& !pixel_valid_o && !pal_mode_o && output_select_o == 2'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	c_valid: cover property (pixel_valid_o);
	c_drive: cover property (!hsync_oe_b_o);
	c_ack: cover property (!serial_bus_data_pin_oe_b_o);
endmodule // venc_pixel_if_props

// ---- bench/venc_src_model.sv ----
// upstream pixel source sending short gated bursts
`timescale 1ns/1ps
module venc_src_model (
	input  wire logic   mclk_i,
	input  wire logic   run_i,
	input  wire logic   wide_i,
	input  wire logic   slow_i,
	output logic [15:0] pixel_bus_o,
	output logic        blank_b_o,
	output logic        hsync_b_o
);
	logic [7:0] exp_q[$];
	logic [8:0] chr_q[$];
	logic [7:0] cnt_r = 8'h00;
	logic [1:0] ph_r = 2'h0;
	logic       gap_r = 1'b0;
	initial begin
		pixel_bus_o = 16'h0000;
		blank_b_o = 1'b0;
		hsync_b_o = 1'b1;
	end
	always @(posedge mclk_i) begin
		// one line sync pulse opens each burst
		hsync_b_o <= !(run_i && cnt_r == 8'h01);
		cnt_r <= run_i ? cnt_r + 8'h01 : 8'h00;
		if (run_i && cnt_r > 8'h08 && !gap_r) begin
			blank_b_o <= 1'b1;
			pixel_bus_o[7:0] <= cnt_r * 8'h0d;
			// upper lines carry junk in 8-bit mode
			pixel_bus_o[15:8] <= pixel_bus_o[15:8] ^ cnt_r ^ 8'h5a;
			if (wide_i || ph_r[0]) begin
				exp_q.push_back(cnt_r * 8'h0d);
			end
			// chroma expected beside each luma: {Cr flag, sample}
			if (wide_i) begin
				chr_q.push_back({ph_r[0], pixel_bus_o[15:8] ^ cnt_r ^ 8'h5a});
			end else if (ph_r[0]) begin
				chr_q.push_back({ph_r[1], pixel_bus_o[7:0]});
			end
			ph_r <= ph_r + 2'h1;
			gap_r <= slow_i && ph_r == 2'h3;
		end else begin
			blank_b_o <= 1'b0;
			pixel_bus_o <= ~pixel_bus_o;
			ph_r <= 2'h0;
			gap_r <= 1'b0;
		end
	end
endmodule // venc_src_model

// ---- bench/tb_top.sv ----
// self-checking bench of the encoder pin interface
`timescale 1ns/1ps
`include "venc_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
	logic        mclk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, luma_o, rtc_phase_o;
	logic [7:0]  chroma_cb_o, chroma_cr_o, rx, px;
	logic [8:0]  cx;
	logic [15:0] pixel_bus_i;
	logic        blank_b_i, hsync_b_i, hsync_b_o, hsync_oe_b_o, src_hs, frame_sync_i;
	logic        frame_sync_o, frame_sync_oe_b_o, serial_bus_data_pin_i, serial_bus_data_pin_o;
	logic        serial_bus_data_pin_oe_b_o, pixel_valid_o, pal_mode_o, e, rd_d = 1'b0;
	logic        subcarrier_multipurpose_input_i = 1'b1, address_select_pin_i = 1'b1;
	logic        serial_bus_clock_pin_i = 1'b1, sda_r = 1'b1, run = 1'b0, wide = 1'b0, slow = 1'b0;
	logic [1:0]  output_select_o;
	logic [2:0]  sc_field_o;
	logic [31:0] r;
	int          error_cnt = 0, check_count = 0, seed = 39664, hs_low = 0;
	logic [7:0]  rq[$];
	always #50 mclk_i = ~mclk_i;
	assign hsync_b_i = hsync_oe_b_o ? src_hs : hsync_b_o;
	assign frame_sync_i = frame_sync_oe_b_o ? 1'b1 : frame_sync_o;
	assign serial_bus_data_pin_i = sda_r & (serial_bus_data_pin_oe_b_o | serial_bus_data_pin_o);
	venc_pixel_if dut (.mclk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .pixel_bus_i, .blank_b_i, .hsync_b_i, .hsync_b_o, .hsync_oe_b_o,
		.frame_sync_i, .frame_sync_o, .frame_sync_oe_b_o, .subcarrier_multipurpose_input_i,
		.address_select_pin_i, .serial_bus_clock_pin_i, .serial_bus_data_pin_i,
		.serial_bus_data_pin_o, .serial_bus_data_pin_oe_b_o, .luma_o, .chroma_cb_o,
		.chroma_cr_o, .pixel_valid_o, .pal_mode_o, .output_select_o, .sc_field_o, .rtc_phase_o);
	venc_src_model src (.mclk_i, .run_i(run), .wide_i(wide), .slow_i(slow),
		.pixel_bus_o(pixel_bus_i), .blank_b_o(blank_b_i), .hsync_b_o(src_hs));
	// oldest note against each read answer and each captured luma sample
	always @(posedge mclk_i) begin
		if (rd_d) begin
			rx = rq.pop_front();
			`CHK(reg_rdata_o, rx)
		end
		if (pixel_valid_o === 1'b1) begin
			px = src.exp_q.pop_front();
			`CHK(luma_o, px)
			cx = src.chr_q.pop_front();
			`CHK(cx[8] ? chroma_cr_o : chroma_cb_o, cx[7:0])
		end
		rd_d <= reg_rd_i;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		cyc(1);
		reg_wr_i <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		rq.push_back(x);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		cyc(1);
		reg_rd_i <= 1'b0;
		cyc(2);
	endtask
	task automatic burst(input logic w, input logic s);
		wide <= w;
		slow <= s;
		run <= 1'b1;
		cyc(40);
		run <= 1'b0;
		cyc(6);
		`CHK(src.exp_q.size(), 0)
	endtask
	// data changes only while the serial clock is low
	task automatic bit_io(input logic d, output logic q);
		serial_bus_clock_pin_i <= 1'b0;
		cyc(4);
		sda_r <= d;
		cyc(4);
		serial_bus_clock_pin_i <= 1'b1;
		cyc(4);
		q = serial_bus_data_pin_i;
		cyc(4);
	endtask
	task automatic send(input logic [7:0] b, output logic q);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], q);
		end
		bit_io(1'b1, q);
	endtask
	task automatic i2c_wr(input logic a, input logic [7:0] d, input logic n);
		logic q;
		sda_r <= 1'b0;
		cyc(8);
		send({`VENC_I2C_BASE, a, 1'b0}, q);
		`CHK(q, n)
		if (!n) begin
			send(`VENC_ADDR_MODE0, q);
			send(d, q);
		end
		bit_io(1'b0, q);
		sda_r <= 1'b1;
		cyc(8);
	endtask
	// read one byte from the current pointer, then refuse further bytes
	task automatic i2c_rd(input logic [7:0] x);
		logic       q;
		logic [7:0] b;
		sda_r <= 1'b0;
		cyc(8);
		send({`VENC_I2C_BASE, address_select_pin_i, 1'b1}, q);
		`CHK(q, 1'b0)
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, q);
			b[i] = q;
		end
		bit_io(1'b1, q);
		bit_io(1'b0, q);
		sda_r <= 1'b1;
		cyc(8);
		`CHK(b, x)
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		cyc(20000);
		error_cnt++;
		conclude();
	end
	initial begin
		cyc(20);
		rst_b_i <= 1'b1;
		cyc(2);
		rd(`VENC_ADDR_MODE0, `VENC_MODE0_RST);
		rd(`VENC_ADDR_MODE2, `VENC_MODE2_RST);
		rd(8'h7f, 8'h00);
		$display("reset test done");
		burst(1'b0, 1'b0);
		burst(1'b0, 1'b1);
		wr(`VENC_ADDR_MODE0, 8'h02);
		burst(1'b1, 1'b1);
		$display("pixel test done");
		for (int m = 0; m < 8; m++) begin
			r = $random(seed);
			wr(`VENC_ADDR_MODE0, {1'b0, r[1:0], m[2], m[1:0], 2'b00});
			cyc(8);
			e = !(m[2] && (m[1:0] == 2'h1 || m[1:0] == 2'h2));
			`CHK(hsync_oe_b_o, e)
			`CHK(frame_sync_oe_b_o, e)
			`CHK(output_select_o, r[1:0])
		end
		// master timing mode 1: one line period holds one line sync pulse
		wr(`VENC_ADDR_MODE0, 8'h14);
		repeat (`VENC_LINE_NTSC) begin
			@(posedge mclk_i);
			hs_low += (hsync_b_o === 1'b0) ? 1 : 0;
		end
		`CHK(hs_low, `VENC_HS_WIDTH)
		`CHK(frame_sync_o, 1'b1)
		wr(`VENC_ADDR_MODE0, 8'h00);
		$display("sync test done");
		wr(`VENC_ADDR_MODE2, 8'h04);
		for (int k = 1; k >= 0; k--) begin
			subcarrier_multipurpose_input_i <= k[0];
			cyc(30);
			`CHK(rtc_phase_o, {8{k[0]}})
		end
		rd(`VENC_ADDR_RTC, 8'h00);
		wr(`VENC_ADDR_MODE2, 8'h02);
		subcarrier_multipurpose_input_i <= 1'b1;
		cyc(4);
		subcarrier_multipurpose_input_i <= 1'b0;
		cyc(4);
		`CHK(sc_field_o, 3'h0)
		rd(`VENC_ADDR_STAT, 8'hc0);
		rd(`VENC_ADDR_STAT, 8'h40);
		$display("subcarrier test done");
		i2c_wr(1'b1, 8'h01, 1'b0);
		`CHK(pal_mode_o, 1'b1)
		i2c_wr(1'b0, 8'h00, 1'b1);
		rd(`VENC_ADDR_MODE0, 8'h01);
		address_select_pin_i <= 1'b0;
		i2c_wr(1'b0, 8'h03, 1'b0);
		rd(`VENC_ADDR_MODE0, 8'h03);
		i2c_rd(8'h03);
		$display("serial test done");
		rst_b_i <= 1'b0;
		cyc(3);
		rst_b_i <= 1'b1;
		cyc(2);
		rd(`VENC_ADDR_MODE0, `VENC_MODE0_RST);
		`CHK(pal_mode_o, 1'b0)
		$display("second reset test done");
		conclude();
	end
endmodule // tb_top
bind venc_pixel_if venc_pixel_if_props chk (.mclk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .blank_b_i, .hsync_oe_b_o, .frame_sync_oe_b_o, .subcarrier_multipurpose_input_i,
	.serial_bus_clock_pin_i, .serial_bus_data_pin_o, .serial_bus_data_pin_oe_b_o, .luma_o,
	.pixel_valid_o, .pal_mode_o, .output_select_o, .sc_field_o, .rtc_phase_o);
